// *** verilog/si_pkg.sv ***
/*
 * si_pkg: constants, register map and carrier types of the status indicator driver.
 * assumes one 100 MHz clock; all status inputs are synchronous to that clock.
 */
package si_pkg;

    // clock and timing
    localparam longint unsigned SI_CLK_HZ        = 100_000_000;  // pclk rate in Hz
    localparam longint unsigned SI_DISP_OFF_S    = 60;           // display sleep time in s
    localparam longint unsigned SI_DISP_OFF_CYC  = SI_DISP_OFF_S * SI_CLK_HZ;
    localparam longint unsigned SI_BLINK_HALF_MS = 250;          // half blink period in ms
    localparam longint unsigned SI_BLINK_HALF_CYC = (SI_BLINK_HALF_MS * SI_CLK_HZ) / 1000;

    // register offsets (byte addresses)
    localparam logic [11:0] SI_OFF_CTRL   = 12'h000;  // mode control, read/write
    localparam logic [11:0] SI_OFF_STATUS = 12'h004;  // led and display state, read only

    // control field positions and reset value
    localparam int          SI_CTRL_RESET_MODE = 0;   // restart interlock configured
    localparam int          SI_CTRL_AUTO_MODE  = 1;   // automatic restart after delay
    localparam int          SI_CTRL_SLEEP_EN   = 2;   // display sleep allowed
    localparam logic [2:0]  SI_CTRL_RST        = 3'h5;

    // status field positions
    localparam int          SI_ST_LEDS  = 0;          // bits 8:0 led vector
    localparam int          SI_ST_DISP  = 12;         // display awake
    localparam int          SI_ST_PAGE  = 16;         // bits 19:16 detail page

    // scanner side status
    typedef struct packed {
        logic safe_on_any;     // at least one safety output on
        logic field_off_any;   // output off due to interrupted field
        logic error_off_any;   // output off due to an error
        logic interlock_trig;  // restart interlock triggered
        logic restart_delay;   // automatic restart delay running
        logic warn_any;        // warning field interrupted
        logic notify;          // other pending notification
    } si_scan_t;

    // network side status
    typedef struct packed {
        logic link_up;         // ethernet link established
        logic traffic;         // data moving on the port
        logic ip_ok;           // connected with an ip address
        logic app_conn;        // application connection open
        logic ip_dup;          // ip address used elsewhere
        logic conn_warn;       // connection interrupted, reset or re-made
        logic conn_lost;       // connection interrupted or terminated
    } si_net_t;

    // module health status
    typedef struct packed {
        logic operating;       // normal operation
        logic sleep_ready;     // sleeping or ready, not yet running
        logic serious_err;     // not operational
        logic minor_err;       // correctable error present
        logic selftest_cfg;    // self test, configuring or config error
    } si_mod_t;

    // led drive vector
    typedef struct packed {
        logic on_green;        // first status led
        logic off_red;         // second status led
        logic restart_yellow;  // third status led
        logic link_green;      // link_activity_led green
        logic link_yellow;     // link_activity_led yellow
        logic net_green;       // network_state_led green
        logic net_red;         // network_state_led red
        logic mod_green;       // module_health_led green
        logic mod_red;         // module_health_led red
    } si_leds_t;

endpackage

// *** verilog/si_status_indicator.sv ***
/*
 * si_status_indicator: turns scanner, network and module status into led patterns,
 * sleeps and wakes the display, steps detail pages, and offers an apb register port.
 * assumes status inputs and the pushbutton are synchronous to pclk and debounced.
 */
// Function
// - green on-led while any output on
// - red off-led steady on field interruption
// - red off-led flashes on error off
// - reset mode: yellow flashes while interlock triggered
// - auto restart: yellow lit during delay
// - yellow steady when warning field interrupted
// - link led steady green on link
// - link led flashes yellow on traffic
// - net led green: ip and application connection
// - net led flashes green without application connection
// - net led steady red on duplicate ip
// - net led flashes red on connection warning
// - net led alternates red/green on lost connection
// - module led steady green in operation
// - module led flashes green sleeping or ready
// - module led steady red on serious error
// - module led flashes red on correctable error
// - module led alternates during test or configuration
// - display off after quiet 60 s
// - brief press wakes a sleeping display
// - press while awake steps detail pages
// - indicators never feed back into safety logic
`timescale 1ns/1ns
module si_status_indicator
    import si_pkg::*;
#(
    parameter longint unsigned DISP_OFF_CYC   = SI_DISP_OFF_CYC,   // display sleep delay
    parameter longint unsigned BLINK_HALF_CYC = SI_BLINK_HALF_CYC, // half blink period
    parameter int              PAGE_W         = 4                  // detail page index width
) (
    input  wire logic              pclk,        // system clock
    input  wire logic              presetn,     // async reset, active low
    input  wire logic              pce,         // clock enable, freezes all state when low
    input  wire logic              psel,        // apb select
    input  wire logic              penable,     // apb access phase
    input  wire logic              pwrite,      // apb direction
    input  wire logic [11:0]       paddr,       // apb byte address
    input  wire logic [31:0]       pwdata,      // apb write data
    output logic      [31:0]       prdata,      // apb read data
    output logic                   pready,      // apb ready
    output logic                   pslverr,     // apb error on unmapped address
    input  wire si_scan_t          scan_st,     // scanner status
    input  wire si_net_t           net_st,      // network status
    input  wire si_mod_t           mod_st,      // module status
    input  wire logic              button,      // pushbutton level, high pressed
    input  wire logic [PAGE_W-1:0] page_count,  // number of detail pages
    output si_leds_t               leds,        // led drive
    output logic                   display_on,  // display awake
    output logic [PAGE_W-1:0]      detail_page, // 0 overview, else detail page
    output logic                   page_marker  // show page count at top right
);

    // blink timer state
    logic [63:0]       blink_cnt;   // cycles within half period
    logic              blink_ph;    // flash phase, high = lit
    // control and display state
    logic [2:0]        ctrl;        // mode control register
    logic [63:0]       quiet_cnt;   // cycles of quiet display
    logic              button_q;    // previous pushbutton level
    logic              press;       // pushbutton press edge
    logic              quiet;       // nothing to show
    si_leds_t          next_leds;   // led pattern for next cycle
    logic              apb_setup;   // apb setup cycle
    logic              apb_done;    // apb completing access
    logic              addr_ok;     // mapped address
    logic [31:0]       status_word; // status register value

    // shared half period timer for every flash pattern
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt <= 64'h0;
            blink_ph  <= 1'b0;
        end else if (pce) begin
            if (blink_cnt >= BLINK_HALF_CYC - 64'h1) begin
                blink_cnt <= 64'h0;
                blink_ph  <= ~blink_ph;
            end else begin
                blink_cnt <= blink_cnt + 64'h1;
            end
        end
    end

    // led pattern selection, higher priority first within each led
    always_comb begin
        next_leds = '0;
        // on-led follows the safety outputs directly
        next_leds.on_green = scan_st.safe_on_any;
        // off-led: error flash outranks the steady field indication
        if (scan_st.error_off_any) begin
            next_leds.off_red = blink_ph;
        end else if (scan_st.field_off_any) begin
            next_leds.off_red = 1'b1;
        end
        // restart / warning led: flash, then delay, then steady warning
        if (ctrl[SI_CTRL_RESET_MODE] && scan_st.interlock_trig) begin
            next_leds.restart_yellow = blink_ph;
        end else if (ctrl[SI_CTRL_AUTO_MODE] && scan_st.restart_delay) begin
            next_leds.restart_yellow = 1'b1;
        end else if (scan_st.warn_any) begin
            next_leds.restart_yellow = 1'b1;
        end
        // link led: traffic flash outranks steady link
        if (net_st.traffic) begin
            next_leds.link_yellow = blink_ph;
        end else if (net_st.link_up) begin
            next_leds.link_green = 1'b1;
        end
        // network led
        if (net_st.ip_dup) begin
            next_leds.net_red = 1'b1;
        end else if (net_st.conn_lost) begin
            next_leds.net_red   = blink_ph;
            next_leds.net_green = ~blink_ph;
        end else if (net_st.conn_warn) begin
            next_leds.net_red = blink_ph;
        end else if (net_st.ip_ok && !net_st.app_conn) begin
            next_leds.net_green = blink_ph;
        end else if (net_st.ip_ok && net_st.app_conn) begin
            next_leds.net_green = 1'b1;
        end
        // module led
        if (mod_st.serious_err) begin
            next_leds.mod_red = 1'b1;
        end else if (mod_st.selftest_cfg) begin
            next_leds.mod_red   = blink_ph;
            next_leds.mod_green = ~blink_ph;
        end else if (mod_st.minor_err) begin
            next_leds.mod_red = blink_ph;
        end else if (mod_st.sleep_ready) begin
            next_leds.mod_green = blink_ph;
        end else if (mod_st.operating) begin
            next_leds.mod_green = 1'b1;
        end
    end

    // led register; outputs only, nothing here returns to safety logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            leds <= '0;
        end else if (pce) begin
            leds <= next_leds;
        end
    end

    // pushbutton press edge
    assign press = button & ~button_q;
    // quiet: all fields clear and nothing pending
    assign quiet = ~(scan_st.field_off_any | scan_st.error_off_any | scan_st.warn_any
                   | scan_st.interlock_trig | scan_st.restart_delay | scan_st.notify);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            button_q <= 1'b0;
        end else if (pce) begin
            button_q <= button;
        end
    end

    // display sleep timer and wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            display_on <= 1'b1;
            quiet_cnt  <= 64'h0;
        end else if (pce) begin
            if (!display_on) begin
                quiet_cnt <= 64'h0;
                if (press || !quiet) begin
                    display_on <= 1'b1;
                end
            end else if (!quiet || press || !ctrl[SI_CTRL_SLEEP_EN]) begin
                quiet_cnt <= 64'h0;                                      // interval restarts
            end else if (quiet_cnt >= DISP_OFF_CYC - 64'h1) begin
                display_on <= 1'b0;
                quiet_cnt  <= 64'h0;
            end else begin
                quiet_cnt <= quiet_cnt + 64'h1;
            end
        end
    end

    // detail page stepping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            detail_page <= '0;
            page_marker <= 1'b0;
        end else if (pce) begin
            page_marker <= display_on && (page_count > PAGE_W'(1));
            if (!display_on) begin
                detail_page <= '0;
            end else if (press) begin
                if (page_count == '0) begin
                    detail_page <= '0;
                end else if (detail_page >= page_count) begin
                    detail_page <= PAGE_W'(1);
                end else begin
                    detail_page <= detail_page + PAGE_W'(1);
                end
            end
        end
    end

    // apb decode
    assign apb_setup = psel & ~penable & ~pready;
    assign apb_done  = psel & penable & pready;
    assign addr_ok   = (paddr == SI_OFF_CTRL) || (paddr == SI_OFF_STATUS);
    assign status_word = {12'h000, 4'(detail_page), 3'h0, display_on, 3'h0, leds};

    // apb answer: one wait-free access phase after each setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (pce) begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~addr_ok;
            if (apb_setup && !pwrite && paddr == SI_OFF_CTRL) begin
                prdata <= {29'h0, ctrl};
            end else if (apb_setup && !pwrite && paddr == SI_OFF_STATUS) begin
                prdata <= status_word;
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // control register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= SI_CTRL_RST;
        end else if (pce && apb_done && pwrite && paddr == SI_OFF_CTRL) begin
            ctrl <= pwdata[2:0];
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ON_LED: assert property (pce |=> leds.on_green == $past(scan_st.safe_on_any))
        else $error("on led does not follow safety outputs");
    AST_OFF_STEADY: assert property (
        pce && scan_st.field_off_any && !scan_st.error_off_any |=> leds.off_red)
        else $error("off led not steady on field interruption");
    AST_OFF_FLASH: assert property (
        pce && scan_st.error_off_any |=> leds.off_red == $past(blink_ph))
        else $error("off led not flashing on error");
    AST_INTERLOCK: assert property (pce && ctrl[SI_CTRL_RESET_MODE] && scan_st.interlock_trig
        |=> leds.restart_yellow == $past(blink_ph))
        else $error("restart led not flashing with interlock");
    AST_DELAY: assert property (pce && ctrl[SI_CTRL_AUTO_MODE] && scan_st.restart_delay
        && !(ctrl[SI_CTRL_RESET_MODE] && scan_st.interlock_trig) |=> leds.restart_yellow)
        else $error("restart led dark during delay");
    AST_DUP_IP: assert property (pce && net_st.ip_dup
        |=> leds.net_red && !leds.net_green)
        else $error("net led not steady red on duplicate ip");
    AST_NET_ALT: assert property (pce && !net_st.ip_dup && net_st.conn_lost
        |=> leds.net_red != leds.net_green)
        else $error("net led not alternating");
    AST_MOD_ERR: assert property (pce && mod_st.serious_err
        |=> leds.mod_red && !leds.mod_green)
        else $error("module led not red on serious error");
    AST_BLINK: assert property (pce && blink_cnt == BLINK_HALF_CYC - 64'h1
        |=> blink_ph != $past(blink_ph) && blink_cnt == 64'h0)
        else $error("blink phase did not toggle at half period");
    AST_SLEEP: assert property (pce && display_on && quiet && !press
        && ctrl[SI_CTRL_SLEEP_EN] && quiet_cnt >= DISP_OFF_CYC - 64'h1 |=> !display_on)
        else $error("display stayed on after quiet interval");
    AST_BUSY_AWAKE: assert property (pce && !quiet |=> display_on)
        else $error("display slept with a pending indication");
    AST_WAKE: assert property (pce && !display_on && press |=> display_on)
        else $error("press did not wake display");
    AST_APB: assert property (apb_setup && pce |=> pready ##1 !pready)
        else $error("apb ready not a single cycle after setup");

    // on-led goes dark once no output is on
    AST_ON_DARK: assert property (pce && !scan_st.safe_on_any |=> !leds.on_green)
        else $error("on led lit with all outputs off");

    // warning field keeps the third led lit unless the interlock flash wins
    AST_WARN: assert property (pce && scan_st.warn_any
        && !(ctrl[SI_CTRL_RESET_MODE] && scan_st.interlock_trig) |=> leds.restart_yellow)
        else $error("restart led dark with warning field");

    // steady link without traffic
    AST_LINK_GREEN: assert property (pce && net_st.link_up && !net_st.traffic
        |=> leds.link_green && !leds.link_yellow)
        else $error("link led not steady green");

    // traffic flashes yellow and hides green
    AST_LINK_FLASH: assert property (pce && net_st.traffic
        |=> leds.link_yellow == $past(blink_ph) && !leds.link_green)
        else $error("link led not flashing yellow on traffic");

    // full connection shows steady green
    AST_NET_GREEN: assert property (pce && net_st.ip_ok && net_st.app_conn && !net_st.ip_dup
        && !net_st.conn_lost && !net_st.conn_warn |=> leds.net_green && !leds.net_red)
        else $error("net led not steady green");

    // ip without application connection flashes green
    AST_NET_FLASH: assert property (pce && net_st.ip_ok && !net_st.app_conn && !net_st.ip_dup
        && !net_st.conn_lost && !net_st.conn_warn
        |=> leds.net_green == $past(blink_ph) && !leds.net_red)
        else $error("net led not flashing green");

    // connection warning flashes red
    AST_NET_WARN: assert property (pce && !net_st.ip_dup && !net_st.conn_lost && net_st.conn_warn
        |=> leds.net_red == $past(blink_ph) && !leds.net_green)
        else $error("net led not flashing red on warning");

    // normal operation shows steady green
    AST_MOD_RUN: assert property (pce && mod_st.operating && !mod_st.serious_err
        && !mod_st.selftest_cfg && !mod_st.minor_err && !mod_st.sleep_ready
        |=> leds.mod_green && !leds.mod_red)
        else $error("module led not steady green");

    // sleeping or ready flashes green
    AST_MOD_READY: assert property (pce && mod_st.sleep_ready && !mod_st.serious_err
        && !mod_st.selftest_cfg && !mod_st.minor_err
        |=> leds.mod_green == $past(blink_ph) && !leds.mod_red)
        else $error("module led not flashing green");

    // correctable error flashes red
    AST_MOD_MINOR: assert property (pce && mod_st.minor_err && !mod_st.serious_err
        && !mod_st.selftest_cfg |=> leds.mod_red == $past(blink_ph) && !leds.mod_green)
        else $error("module led not flashing red");

    // self test or configuration alternates the two colours
    AST_MOD_ALT: assert property (pce && mod_st.selftest_cfg && !mod_st.serious_err
        |=> leds.mod_red == $past(blink_ph) && leds.mod_green != leds.mod_red)
        else $error("module led not alternating");

    // press while awake moves to the next page
    AST_PAGE_STEP: assert property (pce && display_on && press && page_count != '0
        && detail_page < page_count |=> detail_page == $past(detail_page) + PAGE_W'(1))
        else $error("detail page did not step");

    // past the last page the next press wraps to the first detail page
    AST_PAGE_WRAP: assert property (pce && display_on && press && page_count != '0
        && detail_page >= page_count |=> detail_page == PAGE_W'(1))
        else $error("detail page did not wrap");

    COV_SLEEP: cover property (display_on ##1 !display_on);
    COV_WAKE: cover property (!display_on && press ##1 display_on);
    COV_PAGE: cover property (display_on && press && page_count > PAGE_W'(1));
    COV_ALT: cover property (mod_st.selftest_cfg && !mod_st.serious_err ##1 leds.mod_red);

endmodule // si_status_indicator

// *** tb/si_operator.sv ***
/*
 * si_operator: operator model, presses the pushbutton briefly on request.
 * assumes press_req is a one-cycle pulse synchronous to pclk.
 */
`timescale 1ns/1ns
module si_operator #(
    parameter int HOLD = 2      // cycles the button stays pressed
) (
    input  wire logic pclk,     // system clock
    input  wire logic presetn,  // async reset, active low
    input  wire logic press_req,// start one brief press
    output logic      button,   // pushbutton level, high pressed
    output logic      busy      // press or release gap running
);
    int cnt;                    // cycles left in press plus gap

    // press for HOLD cycles, then two low cycles so presses stay apart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
        end else if (press_req) begin
            cnt <= HOLD + 2;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    assign button = (cnt > 2);
    assign busy   = (cnt != 0);
endmodule // si_operator

// *** tb/testbench.sv ***
/*
 * testbench: drives apb, status inputs and the operator model of si_status_indicator.
 * assumes shortened sleep and blink counts given as parameters.
 */
`timescale 1ns/1ns
module testbench;
    import si_pkg::*;
    localparam int OFF_CYC = 50;      // shortened sleep delay
    localparam int HALF    = 4;       // shortened half blink period
    logic        pclk       = 1'h0;   // system clock
    logic        presetn    = 1'h0;   // reset, active low
    logic        pce        = 1'h1;   // clock enable
    logic        psel       = 1'h0;   // apb select
    logic        penable    = 1'h0;   // apb access phase
    logic        pwrite     = 1'h0;   // apb direction
    logic [11:0] paddr      = 12'h000;
    logic [31:0] pwdata     = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    si_scan_t    scan_st    = 7'h01;  // notify keeps display awake early
    si_net_t     net_st     = 7'h00;
    si_mod_t     mod_st     = 5'h00;
    logic        press_req  = 1'h0;
    logic [3:0]  page_count = 4'h3;   // three detail pages
    logic        button;
    logic        busy;
    logic        display_on;
    logic        page_marker;
    logic [3:0]  detail_page;
    si_leds_t    leds;
    logic [31:0] rd;                  // last read data
    logic        err;                 // last slave error
    int          fails      = 0;
    int          num_checks = 0;
    int          cyc        = 0;
    // status input table and expected steady and flashing leds
    logic [6:0]  cs [6] = '{7'h41, 7'h21, 7'h31, 7'h0F, 7'h07, 7'h03};
    logic [6:0]  cn [6] = '{7'h40, 7'h50, 7'h78, 7'h04, 7'h02, 7'h01};
    logic [4:0]  cm [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00};
    logic [8:0]  es [6] = '{9'h122, 9'h0A0, 9'h009, 9'h004, 9'h040, 9'h040};
    logic [8:0]  ef [6] = '{9'h000, 9'h00A, 9'h090, 9'h041, 9'h007, 9'h00C};

    always #5 pclk = ~pclk;

    si_status_indicator #(.DISP_OFF_CYC(OFF_CYC), .BLINK_HALF_CYC(HALF), .PAGE_W(4)) dut (
        .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scan_st(scan_st), .net_st(net_st), .mod_st(mod_st),
        .button(button), .page_count(page_count), .leds(leds), .display_on(display_on),
        .detail_page(detail_page), .page_marker(page_marker));

    si_operator #(.HOLD(2)) op (
        .pclk(pclk), .presetn(presetn), .press_req(press_req), .button(button),
        .busy(busy));

    task automatic give_verdict();
        if (fails == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic set_st(input logic [6:0] s, input logic [6:0] n, input logic [4:0] m);
        @(posedge pclk);
        scan_st <= s;
        net_st  <= n;
        mod_st  <= m;
        repeat (3) @(posedge pclk);
    endtask

    // count lit cycles over two blink periods: steady, flashing or dark
    task automatic obs(input logic [8:0] st, input logic [8:0] fl);
        logic [31:0] c [9];
        logic [31:0] ov;
        ov = 32'h0;
        foreach (c[i]) c[i] = 32'h0;
        repeat (4 * HALF) begin
            @(negedge pclk);
            for (int i = 0; i < 9; i++) c[i] += leds[i];
            ov += (leds.net_red & leds.net_green) | (leds.mod_red & leds.mod_green);
        end
        for (int i = 0; i < 9; i++) chk(c[i], st[i] ? 4 * HALF : (fl[i] ? 2 * HALF : 0));
        chk(ov, 32'h0);
    endtask

    task automatic press();
        @(posedge pclk);
        press_req <= 1'h1;
        @(posedge pclk);
        press_req <= 1'h0;
        do @(negedge pclk); while (busy === 1'h1);
    endtask

    // cut a hang short
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 3000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h5);
        apb(1'h1, 12'h000, 32'hFFFFFFFF);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h7);
        apb(1'h1, 12'h00C, 32'h0);
        chk(err, 1'h1);
        apb(1'h0, 12'h00C, 32'h0);
        chk(err, 1'h1);
        chk(rd, 32'h0);
        apb(1'h1, 12'h004, 32'h0000FFFF);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h7);
        chk(err, 1'h0);
        for (int i = 0; i < 6; i++) begin
            set_st(cs[i], cn[i], cm[i]);
            obs(es[i], ef[i]);
        end
        set_st(7'h00, 7'h00, 5'h00);
        repeat (40) @(negedge pclk);
        chk(display_on, 1'h1);
        for (int n = 0; n < 30 && display_on === 1'h1; n++) @(negedge pclk);
        chk(display_on, 1'h0);
        press();
        chk(display_on, 1'h1);
        chk(detail_page, 4'h0);
        for (int i = 0; i < 4; i++) begin
            press();
            chk(detail_page, i % 3 + 1);
            chk(page_marker, 1'h1);
        end
        apb(1'h0, 12'h004, 32'h0);
        chk(rd, 32'h00011000);
        set_st(7'h01, 7'h00, 5'h00);
        repeat (OFF_CYC + 20) @(negedge pclk);
        chk(display_on, 1'h1);
        @(posedge pclk);
        pce     <= 1'h0;
        scan_st <= 7'h41;
        repeat (5) @(negedge pclk);
        chk(leds.on_green, 1'h0);
        @(posedge pclk);
        pce <= 1'h1;
        repeat (2) @(negedge pclk);
        chk(leds.on_green, 1'h1);
        give_verdict();
    end
endmodule // testbench
